// file: inc/rcs_consts.svh
// Overview of operation
// - Bus address is one, then the address-select pin level, then five zeros.
// - First byte holds the address above a direction bit; one means read.
// - Falling data while clock high is a start; the address byte follows.
// - Every byte moves most significant bit first.
// - A matching address is acknowledged by pulling data low on pulse nine.
// - A foreign address releases the bus and waits for the next start.
// - The second byte is the starting subaddress among eight registers.
// - The subaddress steps forward after each acknowledged data byte, holding at the last register.
// - A stop anywhere returns the slave to idle; a start anywhere restarts address reception.
// - An invalid subaddress is not acknowledged and the slave goes idle.
// - Reading past the last register keeps returning that last register.
// - Control bit zero enables lock-to-reference; bit one enables fine measurement.
// - Lock target rate over two-to-ratio equals reference over two-to-range.
// - Range field resets to the lowest band; higher codes select higher bands.
// - Ratio field n multiplies the divided reference by two to the n.
// - In lock-to-reference mode a loss of lock triggers a new acquisition.
// - A zero-to-one step of the lock enable issues a new lock command.
`ifndef RCS_CONSTS_SVH
`define RCS_CONSTS_SVH
`define RCS_ADDR_HI        1'b1
`define RCS_ADDR_LO        5'h00
`define RCS_BITS_PER_BYTE  4'h8
`define RCS_CNT_ZERO       4'h0
`define RCS_REFCTRL_IDX    3'h0
`define RCS_REG_RST        8'h00
`define RCS_LTR_BIT        0
`define RCS_FINE_BIT       1
`define RCS_RATIO_LSB      2
`define RCS_RATIO_MSB      5
`define RCS_RANGE_LSB      6
`define RCS_RANGE_MSB      7
`define RCS_RANGE_LOWEST   2'h0
`endif

// file: inc/rcs_pkg.sv
`default_nettype none
package rcs_pkg;
  // field order follows the register bit layout, range on top
  typedef struct packed {
    logic [1:0] ref_range;
    logic [3:0] ratio;
    logic       fine_meas_en;
    logic       lock_to_ref_en;
  } rcs_ctrl_t;

  // bus events seen in one clock cycle
  typedef struct packed {
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;
  } rcs_bus_ev_t;

  typedef enum logic [3:0] {
    RCS_IDLE,
    RCS_ADDR,
    RCS_ADDR_ACK,
    RCS_SUB,
    RCS_SUB_ACK,
    RCS_WR,
    RCS_WR_ACK,
    RCS_RD,
    RCS_RD_ACK
  } rcs_state_t;
endpackage : rcs_pkg
`default_nettype wire

// file: rtl/rcs_bus_edge.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_bus_edge (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  // bus lines
  input  wire logic          scl_in,
  input  wire logic          serial_data_line_in,
  // decoded events
  output rcs_pkg::rcs_bus_ev_t ev
);
  import rcs_pkg::*;

  logic scl_q_r;
  logic sda_q_r;

  // previous line levels; idle bus is high so reset to one
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else if (clk_en) begin
      scl_q_r <= scl_in;
      sda_q_r <= serial_data_line_in;
    end
  end

  // clock high on both samples so a clock edge is never mistaken for start or stop
  assign ev.scl_rise = clk_en & scl_in & ~scl_q_r;
  assign ev.scl_fall = clk_en & ~scl_in & scl_q_r;
  assign ev.start    = clk_en & scl_in & scl_q_r & sda_q_r & ~serial_data_line_in;
  assign ev.stop     = clk_en & scl_in & scl_q_r & ~sda_q_r & serial_data_line_in;
  assign ev.sda      = serial_data_line_in;
endmodule : rcs_bus_edge
`default_nettype wire

// file: rtl/rcs_regfile.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcs_consts.svh"
module rcs_regfile #(
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            sys_rst,
  input  wire logic            clk_en,
  // access port
  input  wire logic            wr_en,
  input  wire logic [AW-1:0]   wr_addr,
  input  wire logic [7:0]      wr_data,
  input  wire logic [AW-1:0]   rd_addr,
  output logic      [7:0]      rd_data,
  // recovery loop side
  input  wire logic            loss_of_lock,
  output rcs_pkg::rcs_ctrl_t   ref_ctrl,
  output logic                 lock_cmd
);
  import rcs_pkg::*;

  // every entry must be reachable through the address port
  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_param
    $error("register depth does not fit the address width");
  end

  logic [7:0] mem_r [DEPTH];
  logic       ltr_q_r;
  logic       lol_q_r;
  logic       lock_cmd_r;
  logic       lock_cmd_nxt;

  // one flop row per entry; only complete bytes reach here
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
        mem_r[i] <= `RCS_REG_RST;
      end else if (clk_en && wr_en && (wr_addr == AW'(i))) begin
        mem_r[i] <= wr_data;
      end
    end
  end

  assign rd_data  = mem_r[rd_addr];
  // mode bits, ratio and range feed the loop straight from storage
  assign ref_ctrl = rcs_ctrl_t'(mem_r[`RCS_REFCTRL_IDX]);

  // new lock on enable rising, and re-acquire after a lock loss in that mode
  assign lock_cmd_nxt = (ref_ctrl.lock_to_ref_en & ~ltr_q_r)
                      | (ref_ctrl.lock_to_ref_en & loss_of_lock & ~lol_q_r);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ltr_q_r    <= 1'b0;
      lol_q_r    <= 1'b0;
      lock_cmd_r <= 1'b0;
    end else if (clk_en) begin
      ltr_q_r    <= ref_ctrl.lock_to_ref_en;
      lol_q_r    <= loss_of_lock;
      lock_cmd_r <= lock_cmd_nxt;
    end
  end

  assign lock_cmd = lock_cmd_r;
endmodule : rcs_regfile
`default_nettype wire

// file: rtl/rcs_reference_clock_input_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "rcs_consts.svh"
module rcs_reference_clock_input_ctrl #(
  parameter int REG_COUNT = 8,
  parameter int SUB_W     = 3
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  // strap pin
  input  wire logic          address_select_pin,
  // two-wire bus
  input  wire logic          scl_in,
  input  wire logic          serial_data_line_in,
  output logic               serial_data_line_out,
  output logic               serial_data_line_oe,
  // recovery loop
  input  wire logic          loss_of_lock,
  output rcs_pkg::rcs_ctrl_t ref_ctrl,
  output logic               lock_cmd
);
  import rcs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // parameter checks

  if (REG_COUNT < 2 || REG_COUNT > (1 << SUB_W) || SUB_W > 8) begin : g_bad_param
    $error("register count does not fit the subaddress width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  rcs_bus_ev_t       ev;
  rcs_state_t        st_r;
  rcs_state_t        st_nxt;
  logic [3:0]        cnt_r;
  logic [3:0]        cnt_nxt;
  logic [7:0]        shreg_r;
  logic [7:0]        shreg_nxt;
  logic [7:0]        tx_r;
  logic [7:0]        tx_nxt;
  logic [SUB_W-1:0]  ptr_r;
  logic [SUB_W-1:0]  ptr_nxt;
  logic              rw_r;
  logic              rw_nxt;
  logic              oe_r;
  logic              oe_nxt;
  logic              nack_r;
  logic              nack_nxt;
  logic [6:0]        my_addr;
  logic              byte_done;
  logic              addr_hit;
  logic              sub_ok;
  logic [SUB_W-1:0]  ptr_max;
  logic [SUB_W-1:0]  ptr_inc;
  logic [SUB_W-1:0]  rd_addr;
  logic [7:0]        rd_data;
  logic              wr_en;
  logic [7:0]        shift_in;
  logic [7:0]        tx_shift;

  ////////////////////////////////////////////////////////////////////////////
  // line events

  rcs_bus_edge u_edge (
    .ref_clk             (ref_clk),
    .sys_rst             (sys_rst),
    .clk_en              (clk_en),
    .scl_in              (scl_in),
    .serial_data_line_in (serial_data_line_in),
    .ev                  (ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode

  // strap is read live; a board that moves it mid-transfer gets what it asked for
  assign my_addr   = {`RCS_ADDR_HI, address_select_pin, `RCS_ADDR_LO};
  assign byte_done = (cnt_r == `RCS_BITS_PER_BYTE);
  assign addr_hit  = (shreg_r[7:1] == my_addr);
  assign sub_ok    = (shreg_r < 8'(REG_COUNT));
  assign ptr_max   = SUB_W'(REG_COUNT - 1);
  // saturating step keeps a long read parked on the last register
  assign ptr_inc   = (ptr_r == ptr_max) ? ptr_r : SUB_W'(ptr_r + 1'b1);
  // during the ack slot the next byte is fetched ahead so it is ready at the falling edge
  assign rd_addr   = (st_r == RCS_RD_ACK) ? ptr_inc : ptr_r;
  assign shift_in  = {shreg_r[6:0], ev.sda};
  assign tx_shift  = {tx_r[6:0], 1'b0};
  assign wr_en     = (st_r == RCS_WR) & ev.scl_fall & byte_done & ~ev.start & ~ev.stop;

  // open drain: the pin is only ever pulled low
  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe  = oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // register storage and loop outputs

  rcs_regfile #(
    .DEPTH (REG_COUNT),
    .AW    (SUB_W)
  ) u_regs (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .clk_en       (clk_en),
    .wr_en        (wr_en),
    .wr_addr      (ptr_r),
    .wr_data      (shreg_r),
    .rd_addr      (rd_addr),
    .rd_data      (rd_data),
    .loss_of_lock (loss_of_lock),
    .ref_ctrl     (ref_ctrl),
    .lock_cmd     (lock_cmd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencer

  // start and stop are checked before the state so they win from anywhere
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    shreg_nxt = shreg_r;
    tx_nxt    = tx_r;
    ptr_nxt   = ptr_r;
    rw_nxt    = rw_r;
    oe_nxt    = oe_r;
    nack_nxt  = nack_r;
    if (ev.start) begin
      st_nxt  = RCS_ADDR;
      cnt_nxt = `RCS_CNT_ZERO;
      oe_nxt  = 1'b0;
    end else if (ev.stop) begin
      st_nxt = RCS_IDLE;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        RCS_IDLE: begin
          oe_nxt = 1'b0;
        end
        RCS_ADDR, RCS_SUB, RCS_WR: begin
          if (ev.scl_rise && !byte_done) begin
            shreg_nxt = shift_in;
            cnt_nxt   = cnt_r + 1'b1;
          end else if (ev.scl_fall && byte_done) begin
            cnt_nxt = `RCS_CNT_ZERO;
            if (st_r == RCS_ADDR) begin
              rw_nxt = shreg_r[0];
              st_nxt = addr_hit ? RCS_ADDR_ACK : RCS_IDLE;
              oe_nxt = addr_hit;
            end else if (st_r == RCS_SUB) begin
              st_nxt  = sub_ok ? RCS_SUB_ACK : RCS_IDLE;
              oe_nxt  = sub_ok;
              ptr_nxt = sub_ok ? shreg_r[SUB_W-1:0] : ptr_r;
            end else begin
              st_nxt = RCS_WR_ACK;
              oe_nxt = 1'b1;
            end
          end
        end
        RCS_ADDR_ACK: begin
          if (ev.scl_fall) begin
            if (rw_r) begin
              st_nxt = RCS_RD;
              tx_nxt = rd_data;
              oe_nxt = ~rd_data[7];
            end else begin
              st_nxt = RCS_SUB;
              oe_nxt = 1'b0;
            end
          end
        end
        RCS_SUB_ACK: begin
          if (ev.scl_fall) begin
            st_nxt = RCS_WR;
            oe_nxt = 1'b0;
          end
        end
        RCS_WR_ACK: begin
          if (ev.scl_fall) begin
            st_nxt  = RCS_WR;
            oe_nxt  = 1'b0;
            ptr_nxt = ptr_inc;
          end
        end
        RCS_RD: begin
          if (ev.scl_rise && !byte_done) begin
            cnt_nxt = cnt_r + 1'b1;
          end else if (ev.scl_fall) begin
            if (byte_done) begin
              st_nxt  = RCS_RD_ACK;
              cnt_nxt = `RCS_CNT_ZERO;
              oe_nxt  = 1'b0;
            end else begin
              tx_nxt = tx_shift;
              oe_nxt = ~tx_shift[7];
            end
          end
        end
        RCS_RD_ACK: begin
          if (ev.scl_rise) begin
            nack_nxt = ev.sda;
          end else if (ev.scl_fall) begin
            if (nack_r) begin
              st_nxt = RCS_IDLE;
              oe_nxt = 1'b0;
            end else begin
              st_nxt  = RCS_RD;
              ptr_nxt = ptr_inc;
              tx_nxt  = rd_data;
              oe_nxt  = ~rd_data[7];
            end
          end
        end
        default: begin
          st_nxt = RCS_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // sequencer flops
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r    <= RCS_IDLE;
      cnt_r   <= `RCS_CNT_ZERO;
      shreg_r <= `RCS_REG_RST;
      tx_r    <= `RCS_REG_RST;
      ptr_r   <= `RCS_REFCTRL_IDX;
      rw_r    <= 1'b0;
      oe_r    <= 1'b0;
      nack_r  <= 1'b0;
    end else if (clk_en) begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      shreg_r <= shreg_nxt;
      tx_r    <= tx_nxt;
      ptr_r   <= ptr_nxt;
      rw_r    <= rw_nxt;
      oe_r    <= oe_nxt;
      nack_r  <= nack_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst || !clk_en);

  sequence s_byte_end(rcs_state_t s);
    (st_r == s) && ev.scl_fall && byte_done && !ev.start && !ev.stop;
  endsequence

  chk_addr_ack_drive: assert property (
    s_byte_end(RCS_ADDR) ##0 (shreg_r[7:1] == {1'b1, address_select_pin, 5'h00})
    |=> (st_r == RCS_ADDR_ACK) && serial_data_line_oe)
    else $error("matching address not acknowledged");

  chk_addr_miss_idle: assert property (
    s_byte_end(RCS_ADDR) ##0 !addr_hit |=> (st_r == RCS_IDLE) && !serial_data_line_oe)
    else $error("foreign address did not release the bus");

  chk_start_restart: assert property (
    ev.start |=> (st_r == RCS_ADDR) && (cnt_r == 4'h0) && !serial_data_line_oe)
    else $error("start did not restart address reception");

  chk_stop_to_idle: assert property (
    (ev.stop && !ev.start) |=> (st_r == RCS_IDLE) && !serial_data_line_oe)
    else $error("stop did not return to idle");

  chk_bad_sub_nack: assert property (
    s_byte_end(RCS_SUB) ##0 (shreg_r >= 8'(REG_COUNT)) |=> (st_r == RCS_IDLE) ##1 !serial_data_line_oe)
    else $error("invalid subaddress was acknowledged");

  chk_write_commit: assert property (
    s_byte_end(RCS_WR) ##0 (ptr_r == `RCS_REFCTRL_IDX)
    |=> (ref_ctrl == rcs_ctrl_t'($past(shreg_r))) && serial_data_line_oe)
    else $error("written byte not stored and acknowledged");

  chk_read_saturate: assert property (
    (st_r == RCS_RD_ACK) && ev.scl_fall && !nack_r && !ev.start && !ev.stop && (ptr_r == ptr_max)
    |=> (ptr_r == ptr_max) && (st_r == RCS_RD) && (tx_r == $past(rd_data)))
    else $error("read past the last register moved on");

  chk_lock_command: assert property (
    $rose(ref_ctrl.lock_to_ref_en) |=> lock_cmd)
    else $error("lock command missing after enable rise");

  chk_read_release: assert property (
    s_byte_end(RCS_RD) |=> (st_r == RCS_RD_ACK) && !serial_data_line_oe)
    else $error("data not released for the acknowledge slot");

  // one clock high phase closing with no start or stop beside it
  sequence s_slot_end(rcs_state_t s);
    (st_r == s) && ev.scl_fall && !ev.start && !ev.stop;
  endsequence

  // direction bit steers the turn-around after the address acknowledge
  chk_dir_capture: assert property (
    s_byte_end(RCS_ADDR) ##0 addr_hit ##0 shreg_r[0] |=> rw_r)
    else $error("read direction not captured");

  chk_read_turn: assert property (
    s_slot_end(RCS_ADDR_ACK) ##0 rw_r |=> (st_r == RCS_RD) && (serial_data_line_oe == !tx_r[7]))
    else $error("read did not start driving the first bit");

  chk_write_turn: assert property (
    s_slot_end(RCS_ADDR_ACK) ##0 !rw_r |=> (st_r == RCS_SUB) && !serial_data_line_oe)
    else $error("write did not release the bus for the subaddress");

  // pointer load and stepping on the write path
  chk_sub_load: assert property (
    s_byte_end(RCS_SUB) ##0 (shreg_r < 8'(REG_COUNT))
    |=> (st_r == RCS_SUB_ACK) && (ptr_r == SUB_W'($past(shreg_r))) && serial_data_line_oe)
    else $error("valid subaddress not loaded and acknowledged");

  chk_write_step: assert property (
    s_slot_end(RCS_WR_ACK) ##0 (ptr_r != ptr_max)
    |=> (st_r == RCS_WR) && (ptr_r == SUB_W'($past(ptr_r) + 1'b1)) && !serial_data_line_oe)
    else $error("subaddress did not advance after a written byte");

  // read bits: a zero pulls the line, a one leaves it to the pull-up
  chk_read_zero: assert property (
    s_slot_end(RCS_RD) ##0 !byte_done ##0 !tx_r[6] |=> serial_data_line_oe)
    else $error("zero read bit not pulled low");

  chk_read_one: assert property (
    s_slot_end(RCS_RD) ##0 !byte_done ##0 tx_r[6] |=> !serial_data_line_oe)
    else $error("one read bit not released");

  chk_nack_idle: assert property (
    s_slot_end(RCS_RD_ACK) ##0 nack_r |=> (st_r == RCS_IDLE) && !serial_data_line_oe)
    else $error("read went on after a no-acknowledge");

  // lock command sources; none may fire outside lock-to-reference mode
  chk_relock_loss: assert property (
    ref_ctrl.lock_to_ref_en && $rose(loss_of_lock) |=> lock_cmd)
    else $error("no new lock after a loss of lock");

  chk_lock_mode_only: assert property (
    !ref_ctrl.lock_to_ref_en |=> !lock_cmd)
    else $error("lock command outside lock-to-reference mode");
endmodule : rcs_reference_clock_input_ctrl
`default_nettype wire

// file: sim/rcs_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module rcs_bus_master (
  // clock and resolved data wire
  input  wire logic       ref_clk,
  input  wire logic       sda,
  // driven lines, data is open drain
  output var logic        scl,
  output var logic        sda_low,
  // acknowledge levels and read bytes seen
  output var logic        obs_valid,
  output var logic [7:0]  obs_data
);
  int q = 4; // quarter bus period in cycles, raised for slow runs
  // clock stands high and data is released outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    obs_valid = 1'b0;
    obs_data = 8'h00;
  end
  //////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic note(input logic [7:0] d);
    obs_data <= d;
    obs_valid <= 1'b1;
    tick(1);
    obs_valid <= 1'b0;
  endtask : note
  // data only moves while the clock is low
  task automatic slot(input logic low, output logic seen);
    sda_low <= low;
    tick(q);
    scl <= 1'b1;
    tick(2 * q);
    seen = sda;
    scl <= 1'b0;
    tick(q);
  endtask : slot
  // falling data under a high clock, also a repeated start
  task automatic start();
    sda_low <= 1'b0;
    tick(q);
    scl <= 1'b1;
    tick(q);
    sda_low <= 1'b1;
    tick(q);
    scl <= 1'b0;
    tick(q);
  endtask : start
  // a single stop in one clock-high phase
  task automatic stop();
    sda_low <= 1'b1;
    tick(q);
    scl <= 1'b1;
    tick(q);
    sda_low <= 1'b0;
    tick(2 * q);
  endtask : stop
  // short counts cut a frame off mid-byte
  task automatic wr_byte(input logic [7:0] b, input int nbits);
    logic s;
    for (int i = 7; i > 7 - nbits; i--) slot(~b[i], s);
    if (nbits == 8) begin
      slot(1'b0, s);
      note({7'h00, s});
    end
  endtask : wr_byte
  task automatic rd_byte(input logic last);
    logic [7:0] v;
    logic s;
    for (int i = 7; i >= 0; i--) slot(1'b0, v[i]);
    note(v);
    slot(~last, s);
  endtask : rd_byte
endmodule : rcs_bus_master
`default_nettype wire

// file: sim/tb_i2c_reference_clock_input_control_slave.sv
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_reference_clock_input_control_slave;
  import rcs_pkg::*;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       clk_en = 1'b1;
  logic       addr_pin = 1'b0;
  logic       lol = 1'b0;
  logic       scl, m_low, dut_out, dut_oe, obs_valid, lock_cmd;
  logic [7:0] obs_data;
  rcs_ctrl_t  ctrl;
  logic [7:0] exp_q[$];
  logic [7:0] wq[$];
  logic [7:0] regs[8];
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         n_lock = 0;
  int         exp_lock = 0;
  // open-drain wire with pull-up, both parties may pull low
  wire        sda_w = ~m_low & (dut_oe ? dut_out : 1'b1);

  always #50 ref_clk = ~ref_clk;
  rcs_reference_clock_input_ctrl #(.REG_COUNT(8), .SUB_W(3)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .address_select_pin(addr_pin), .scl_in(scl), .serial_data_line_in(sda_w), .serial_data_line_out(dut_out),
    .serial_data_line_oe(dut_oe), .loss_of_lock(lol), .ref_ctrl(ctrl), .lock_cmd(lock_cmd));
  rcs_bus_master m (.ref_clk(ref_clk), .sda(sda_w), .scl(scl), .sda_low(m_low), .obs_valid(obs_valid),
    .obs_data(obs_data));
  //////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test
  function automatic logic [7:0] addr_byte(input logic rw);
    return {1'b1, addr_pin, 5'h00, rw};
  endfunction : addr_byte
  // each byte sent notes the acknowledge level it should get
  task automatic wr(input logic [7:0] b, input logic lvl);
    exp_q.push_back({7'h00, lvl});
    m.wr_byte(b, 8);
  endtask : wr
  task automatic rd(input logic [7:0] e, input logic last);
    exp_q.push_back(e);
    m.rd_byte(last);
  endtask : rd
  // pointer saturates at the last register, as chosen for writes
  task automatic write_seq(input logic [7:0] sub);
    logic [2:0] p;
    p = sub[2:0];
    m.start();
    wr(addr_byte(1'b0), 1'b0);
    wr(sub, 1'b0);
    while (wq.size() > 0) begin
      if (p == 3'h0 && wq[0][0] && !regs[0][0]) exp_lock++;
      regs[p] = wq[0];
      wr(wq.pop_front(), 1'b0);
      if (p != 3'h7) p++;
    end
    m.stop();
    check("ref_ctrl", ctrl, regs[0]);
  endtask : write_seq
  task automatic read_seq(input logic [7:0] sub, input int n);
    logic [2:0] p;
    p = sub[2:0];
    m.start();
    wr(addr_byte(1'b0), 1'b0);
    wr(sub, 1'b0);
    m.start();
    wr(addr_byte(1'b1), 1'b0);
    for (int i = 0; i < n; i++) begin
      rd(regs[p], i == n - 1);
      if (p != 3'h7) p++;
    end
    m.stop();
  endtask : read_seq
  //////////////////////////////////////////////////////////////
  // oldest note is matched against each acknowledge or read byte
  always @(posedge ref_clk) begin
    if (lock_cmd === 1'b1) n_lock++;
    if (obs_valid === 1'b1) begin
      if (exp_q.size() == 0) check("bus_obs", obs_data, 8'hxx);
      else check("bus_obs", obs_data, exp_q.pop_front());
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'h0626));
    foreach (regs[i]) regs[i] = 8'h00;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    tick(2);
    check("ref_ctrl", ctrl, 8'h00);
    check("sda_oe", {7'h00, dut_oe}, 8'h00);
    // one address bit off at a time, for both strap levels
    for (int v = 0; v < 2; v++) begin
      addr_pin <= v[0];
      tick(1);
      for (int k = 1; k < 8; k++) begin
        m.start();
        wr(addr_byte(1'b0) ^ (8'h01 << k), 1'b1);
        wr(8'h00, 1'b1);
        m.stop();
      end
      read_seq(8'h00, 2);
    end
    // every range band, ratio codes 0000 and 1000 among them
    for (int r = 0; r < 4; r++) begin
      wq.push_back({r[1:0], (r == 0) ? 4'h0 : (r == 1) ? 4'h8 : 4'($urandom_range(0, 15)), 2'b01});
      write_seq(8'h00);
    end
    wq.push_back(regs[0] & 8'hfe);
    write_seq(8'h00);
    wq.push_back(regs[0] | 8'h01);
    write_seq(8'h00);
    wq.push_back(8'h02);
    write_seq(8'h00);
    // back-to-back writes past the top, then a slow overrunning read
    repeat (4) wq.push_back(8'($urandom));
    write_seq(8'h05);
    m.q = 7;
    read_seq(8'h05, 5);
    m.q = 4;
    read_seq(8'h00, 8);
    // subaddresses out of range are refused and the slave goes idle
    for (int i = 0; i < 3; i++) begin
      m.start();
      wr(addr_byte(1'b0), 1'b0);
      wr((i == 0) ? 8'h08 : (i == 1) ? 8'hff : 8'($urandom_range(8, 255)), 1'b1);
      wr(8'h55, 1'b1);
      m.stop();
    end
    // stop and start in mid-byte drop the partial byte
    m.start();
    wr(addr_byte(1'b0), 1'b0);
    wr(8'h00, 1'b0);
    m.wr_byte(~regs[0], 4);
    m.stop();
    check("ref_ctrl", ctrl, regs[0]);
    m.start();
    wr(addr_byte(1'b0), 1'b0);
    m.wr_byte(8'h00, 3);
    m.start();
    wr(addr_byte(1'b1), 1'b0);
    rd(regs[0], 1'b1);
    m.stop();
    // loss of lock relocks only in lock-to-reference mode
    wq.push_back(8'h01);
    write_seq(8'h00);
    for (int e = 0; e < 2; e++) begin
      lol <= 1'b1;
      if (regs[0][0]) exp_lock++;
      tick(4);
      lol <= 1'b0;
      tick(4);
      wq.push_back(8'h00);
      write_seq(8'h00);
    end
    clk_en <= 1'b0;
    tick(3);
    clk_en <= 1'b1;
    tick(2);
    check("ref_ctrl", ctrl, regs[0]);
    check("lock_cmds", 8'(n_lock), 8'(exp_lock));
    check("notes_left", 8'(exp_q.size()), 8'h00);
    stop_test();
  end
  // watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end
endmodule : tb_i2c_reference_clock_input_control_slave
`default_nettype wire
